// ===== hdl/pec_event_log.sv
// link event counter bank and its log page word stream
`timescale 1ns/1ps
// Behaviour
// - each log entry starts with a 16-bit identifier, value follows
// - unused slots after the entries are filled with identifier zero
// - unimplemented optional counters never appear in the page
// - a zero value means no event of that kind was recorded
// - entry order is free; bank order is used
// - identifier bits 14:12 carry width code, 1h means 16 bits
// - every value occupies a whole multiple of sixteen bits
// - bit 15 marks vendor counters; none here, so bit 15 is zero
// - identifier zero is a terminator with no value after it
// - counter 001h counts commands ending with error and crc bits set
// - counter 002h counts data frames refused in either direction
// - counter 003h counts sent data frames the host refused
// - counter 004h counts received data frames the device refused
// - counter 005h counts refused non-data frames both ways, retries too
// - counter 006h counts sent non-data frames refused, with retries
// - counter 007h counts received non-data frames refused, retries too
// - counter 009h counts each link not-ready to ready change
// - counter 00Ah counts reset signature frames the host acknowledged
// - counter 00Bh counts received frames refused for crc error
// - counter 00Dh counts received frames refused for other causes
// - retry and per-cause counters 008h, 00Fh to 013h are absent
// - transmitted means device to host, received means host to device
// - counters stop at maximum and never wrap
// - a self-test activation frame clears every counter
// - log read with clear flag returns values, then clears counters
// - counters survive link and soft resets, not power loss
module pec_event_log (
  // clock and power-up reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // command completion
  input  wire logic        cmd_done,
  input  wire logic        cmd_status_err,
  input  wire logic        cmd_err_icrc,
  // frames sent by the device and answered by the host
  input  wire logic        tx_rerr,
  input  wire logic        tx_is_data,
  // frames received by the device and refused by it
  input  wire logic        rx_rerr,
  input  wire logic        rx_is_data,
  input  wire logic        rx_crc_cause,
  // link state
  input  wire logic        phy_ready,
  // reset signature frame
  input  wire logic        sig_fis_done,
  input  wire logic        sig_fis_rok,
  // counter clear by self-test activation frame
  input  wire logic        bist_activate,
  // log page read request
  input  wire logic        log_req,
  input  wire logic        log_clear,
  // log page word stream
  output logic             word_valid,
  input  wire logic        word_ready,
  output logic      [15:0] word_data,
  output logic             word_last,
  output logic             log_busy
);

  // ***************************************************************
  // event decode
  // ***************************************************************
  // tx_* are device-to-host items, rx_* host-to-device items
  wire tx_data_ev = tx_rerr && tx_is_data;
  wire tx_nd_ev   = tx_rerr && !tx_is_data;
  wire rx_data_ev = rx_rerr && rx_is_data;
  wire rx_nd_ev   = rx_rerr && !rx_is_data;
  wire phy_rise;

  // both directions may report in one cycle; the two-way counters
  // take one count per cycle and owe the rest to the next cycles
  logic                        data_all_ev;
  logic                        nd_all_ev;
  logic [pec_pkg::NUM_CNT-1:0] ev;

  assign ev[pec_pkg::I_ICRC] =
    cmd_done && cmd_status_err && cmd_err_icrc;
  assign ev[pec_pkg::I_DATA_ALL] = data_all_ev;
  assign ev[pec_pkg::I_DATA_TX]  = tx_data_ev;
  assign ev[pec_pkg::I_DATA_RX]  = rx_data_ev;
  // each refused retry arrives as its own pulse
  assign ev[pec_pkg::I_ND_ALL]   = nd_all_ev;
  assign ev[pec_pkg::I_ND_TX]    = tx_nd_ev;
  assign ev[pec_pkg::I_ND_RX]    = rx_nd_ev;
  assign ev[pec_pkg::I_PHY_RDY]  = phy_rise;
  assign ev[pec_pkg::I_SIG_FIS]  = sig_fis_done && sig_fis_rok;
  assign ev[pec_pkg::I_RX_CRC]   = rx_rerr && rx_crc_cause;
  assign ev[pec_pkg::I_RX_OTHER] = rx_rerr && !rx_crc_cause;

  pec_rise_det u_phy_rise (
    .sys_clk (sys_clk),
    .rst     (rst),
    .level   (phy_ready),
    .rise    (phy_rise)
  );

  // ***************************************************************
  // read sequencer state
  // ***************************************************************
  pec_pkg::pec_state_t state_q;
  pec_pkg::pec_state_t state_d;
  logic [pec_pkg::IDX_W-1:0] idx_q;
  logic [pec_pkg::IDX_W-1:0] idx_d;
  logic                      valid_q;
  logic                      valid_d;
  logic [15:0]               data_q;
  logic [15:0]               data_d;
  logic                      last_q;
  logic                      last_d;
  logic                      clr_pend_q;
  logic                      clr_pend_d;

  wire start    = (state_q == pec_pkg::PEC_IDLE) && log_req;
  wire take     = valid_q && word_ready;
  wire finish   = take && last_q;
  // clear after the final word leaves, so the page shows old values
  wire read_clr = finish && clr_pend_q;
  wire cnt_clr  = bist_activate || read_clr;

  // ***************************************************************
  // counter bank
  // ***************************************************************
  // owed counts for the two-way counters; two bits cover far longer
  // runs of double reports than the link can produce back to back
  logic [1:0] data_owe_q;
  logic [1:0] data_owe_d;
  logic [1:0] nd_owe_q;
  logic [1:0] nd_owe_d;
  wire  [2:0] data_sum  = {1'h0, data_owe_q} + {2'h0, tx_data_ev}
                          + {2'h0, rx_data_ev};
  wire  [2:0] nd_sum    = {1'h0, nd_owe_q} + {2'h0, tx_nd_ev}
                          + {2'h0, rx_nd_ev};
  wire  [2:0] data_left = data_sum - 3'h1;
  wire  [2:0] nd_left   = nd_sum - 3'h1;

  // owed counts predate a clear and are dropped with it
  assign data_all_ev = cnt_clr ? (tx_data_ev || rx_data_ev)
                               : (data_sum != 3'h0);
  assign nd_all_ev   = cnt_clr ? (tx_nd_ev || rx_nd_ev)
                               : (nd_sum != 3'h0);
  assign data_owe_d  = cnt_clr ? {1'h0, tx_data_ev && rx_data_ev} :
                       (data_sum == 3'h0) ? 2'h0 :
                       (data_left > 3'h3) ? 2'h3 : data_left[1:0];
  assign nd_owe_d    = cnt_clr ? {1'h0, tx_nd_ev && rx_nd_ev} :
                       (nd_sum == 3'h0) ? 2'h0 :
                       (nd_left > 3'h3) ? 2'h3 : nd_left[1:0];

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      data_owe_q <= 2'h0;
      nd_owe_q   <= 2'h0;
    end else begin
      data_owe_q <= data_owe_d;
      nd_owe_q   <= nd_owe_d;
    end
  end

  // only power-up reset reaches the bank; link and soft resets do not
  // enter this block at all
  logic [pec_pkg::NUM_CNT-1:0][pec_pkg::CNT_W-1:0] cnt_val;
  logic [pec_pkg::NUM_CNT-1:0][pec_pkg::CNT_W-1:0] snap_q;

  genvar g;
  generate
    for (g = 0; g < pec_pkg::NUM_CNT; g++) begin : g_cnt
      pec_counter #(
        .W (pec_pkg::CNT_W)
      ) u_cnt (
        .sys_clk (sys_clk),
        .rst     (rst),
        .clr     (cnt_clr),
        .inc     (ev[g]),
        .value   (cnt_val[g])
      );
    end
  endgenerate

  // values are frozen at request time so the page is consistent
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      snap_q <= '0;
    end else if (start) begin
      snap_q <= cnt_val;
    end
  end

  // ***************************************************************
  // word selection
  // ***************************************************************
  // page word n holds bytes 2n and 2n+1; words 0..1 are the reserved
  // header, then identifier/value pairs, then zero fill
  wire [pec_pkg::IDX_W-1:0] sel_idx  = start ? '0 : idx_q + 8'h01;
  wire                      in_entry =
    (sel_idx >= pec_pkg::HDR_WORDS) &&
    (sel_idx < pec_pkg::HDR_WORDS + pec_pkg::ENTRY_WORDS);
  wire [pec_pkg::IDX_W-1:0] ent_off  = sel_idx - pec_pkg::HDR_WORDS;
  wire [3:0]                ent_num  = ent_off[4:1];
  wire                      ent_val  = ent_off[0];
  wire                      last_sel = (sel_idx == pec_pkg::LAST_IDX);
  wire [pec_pkg::CNT_W-1:0] snap_sel =
    start ? cnt_val[ent_num] : snap_q[ent_num];

  // identifier: standard range, 16-bit width code, counter code
  wire [15:0] id_sel = {1'b0,
                        pec_pkg::WCODE_16,
                        pec_pkg::CODES[ent_num]};

  logic [15:0] word_sel;

  // values fill a full 16-bit word, the counter width itself
  always_comb begin
    word_sel = pec_pkg::ID_END;
    if (in_entry) begin
      word_sel = ent_val ? snap_sel : id_sel;
    end
  end
  // the first zero word after the entries is the terminator
  // only implemented counters are listed, in bank order
  // retry and per-cause codes are never emitted
  // the bank never holds a nonzero value without an event

  // ***************************************************************
  // read sequencer
  // ***************************************************************
  always_comb begin
    state_d    = state_q;
    idx_d      = idx_q;
    valid_d    = valid_q;
    data_d     = data_q;
    last_d     = last_q;
    clr_pend_d = clr_pend_q;
    case (state_q)
      pec_pkg::PEC_IDLE: begin
        if (log_req) begin
          state_d    = pec_pkg::PEC_SEND;
          idx_d      = '0;
          valid_d    = 1'b1;
          data_d     = word_sel;
          last_d     = 1'b0;
          clr_pend_d = log_clear;
        end
      end
      pec_pkg::PEC_SEND: begin
        if (finish) begin
          state_d    = pec_pkg::PEC_IDLE;
          valid_d    = 1'b0;
          data_d     = '0;
          last_d     = 1'b0;
          clr_pend_d = 1'b0;
        end else if (take) begin
          idx_d  = sel_idx;
          data_d = word_sel;
          last_d = last_sel;
        end
      end
      default: begin
        state_d = pec_pkg::PEC_IDLE;
        valid_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q    <= pec_pkg::PEC_IDLE;
      idx_q      <= '0;
      valid_q    <= 1'b0;
      data_q     <= '0;
      last_q     <= 1'b0;
      clr_pend_q <= 1'b0;
    end else begin
      state_q    <= state_d;
      idx_q      <= idx_d;
      valid_q    <= valid_d;
      data_q     <= data_d;
      last_q     <= last_d;
      clr_pend_q <= clr_pend_d;
    end
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  assign word_valid = valid_q;
  assign word_data  = data_q;
  assign word_last  = last_q;
  assign log_busy   = valid_q;

endmodule

// ===== hdl/pec_pkg.sv
// constants shared by the link event counter block
package pec_pkg;

  // ***************************************************************
  // counter geometry
  // ***************************************************************
  localparam int NUM_CNT = 11;
  localparam int CNT_W   = 16;

  // significant-width codes for identifier bits 14:12
  localparam logic [2:0] WCODE_16 = 3'h1;
  localparam logic [2:0] WCODE_32 = 3'h2;
  localparam logic [2:0] WCODE_48 = 3'h3;
  localparam logic [2:0] WCODE_64 = 3'h4;

  // identifier bit positions
  localparam int ID_VENDOR_BIT = 15;
  localparam int ID_WIDTH_LSB  = 12;
  localparam int ID_CODE_W     = 12;

  // counter codes, identifier bits 11:0
  localparam logic [11:0] CODE_END      = 12'h000;
  localparam logic [11:0] CODE_ICRC     = 12'h001;
  localparam logic [11:0] CODE_DATA_ALL = 12'h002;
  localparam logic [11:0] CODE_DATA_TX  = 12'h003;
  localparam logic [11:0] CODE_DATA_RX  = 12'h004;
  localparam logic [11:0] CODE_ND_ALL   = 12'h005;
  localparam logic [11:0] CODE_ND_TX    = 12'h006;
  localparam logic [11:0] CODE_ND_RX    = 12'h007;
  localparam logic [11:0] CODE_PHY_RDY  = 12'h009;
  localparam logic [11:0] CODE_SIG_FIS  = 12'h00a;
  localparam logic [11:0] CODE_RX_CRC   = 12'h00b;
  localparam logic [11:0] CODE_RX_OTHER = 12'h00d;

  // slot index of each counter in the bank
  localparam int I_ICRC     = 0;
  localparam int I_DATA_ALL = 1;
  localparam int I_DATA_TX  = 2;
  localparam int I_DATA_RX  = 3;
  localparam int I_ND_ALL   = 4;
  localparam int I_ND_TX    = 5;
  localparam int I_ND_RX    = 6;
  localparam int I_PHY_RDY  = 7;
  localparam int I_SIG_FIS  = 8;
  localparam int I_RX_CRC   = 9;
  localparam int I_RX_OTHER = 10;

  // full 16-bit identifier, all counters standard and 16 bits wide
  localparam logic [15:0] ID_END = 16'h0000;
  localparam logic [NUM_CNT-1:0][11:0] CODES = {
    CODE_RX_OTHER, CODE_RX_CRC, CODE_SIG_FIS, CODE_PHY_RDY,
    CODE_ND_RX, CODE_ND_TX, CODE_ND_ALL, CODE_DATA_RX,
    CODE_DATA_TX, CODE_DATA_ALL, CODE_ICRC};

  // ***************************************************************
  // log page word stream (16-bit words, bytes 0..509)
  // ***************************************************************
  localparam int         IDX_W       = 8;
  localparam logic [7:0] HDR_WORDS   = 8'h02;
  localparam logic [7:0] ENTRY_WORDS = 8'h16;
  localparam logic [7:0] LAST_IDX    = 8'hfe;
  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_MAX   = 16'hffff;

  typedef enum logic [0:0] {
    PEC_IDLE,
    PEC_SEND
  } pec_state_t;

endpackage

// ===== hdl/pec_counter.sv
// one saturating event counter
`timescale 1ns/1ps
module pec_counter #(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst,
  // control
  input  wire logic         clr,
  input  wire logic         inc,
  // value
  output logic      [W-1:0] value
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  wire          at_max = &cnt_q;

  // a clear and an event in the same cycle leave one count behind
  always_comb begin
    cnt_d = cnt_q;
    if (clr) begin
      cnt_d = inc ? W'(1) : '0;
    end else if (inc && !at_max) begin
      cnt_d = cnt_q + W'(1);
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign value = cnt_q;

endmodule

// ===== hdl/pec_rise_det.sv
// rising edge detector for a level input
`timescale 1ns/1ps
module pec_rise_det (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // level in, pulse out
  input  wire logic level,
  output logic      rise
);

  logic level_q;

  // reset low so a link already up at power-up is counted as one rise
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      level_q <= 1'b0;
    end else begin
      level_q <= level;
    end
  end

  assign rise = level && !level_q;

endmodule

// ===== testbench/pec_event_log_checker.sv
// concurrent checks on the log page word stream
`timescale 1ns/1ps
module pec_event_log_checker (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rst,
  // read request
  input wire logic        log_req,
  input wire logic        log_busy,
  // word stream
  input wire logic        word_valid,
  input wire logic        word_ready,
  input wire logic [15:0] word_data,
  input wire logic        word_last
);
  // ****************
  // word position
  // ****************
  logic [7:0] idx_q;
  logic [7:0] idx_d;
  logic       take;
  logic       is_id;
  logic       is_pad;
  assign take   = word_valid && word_ready;
  assign idx_d  = !take ? idx_q : word_last ? 8'h00 : idx_q + 8'h01;
  assign is_id  = idx_q >= 8'h02 && idx_q <= 8'h16 && !idx_q[0];
  assign is_pad = idx_q < 8'h02 || idx_q >= 8'h18;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      idx_q <= 8'h00;
    end else begin
      idx_q <= idx_d;
    end
  end
  // ****************
  // properties
  // ****************
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  hold_word_a: assert property (
    word_valid && !word_ready |=> word_valid && $stable(word_data)
      && $stable(word_last)) else $error("word changed while stalled");
  req_start_a: assert property (
    log_req && !log_busy |=> word_valid && word_data == 16'h0000
      && !word_last) else $error("page did not open with header");
  id_width_a: assert property (
    word_valid && is_id |-> word_data[15:12] == 4'h1)
    else $error("bad width or vendor bits");
  id_code_a: assert property (
    word_valid && is_id |->
      word_data[11:0] == pec_pkg::CODES[idx_q[4:1] - 4'h1])
    else $error("unexpected counter code");
  pad_zero_a: assert property (
    word_valid && is_pad |-> word_data == 16'h0000)
    else $error("slot past terminator not zero");
  last_pos_a: assert property (
    word_valid |-> word_last == (idx_q == 8'hfe))
    else $error("last word at wrong place");
  page_end_a: assert property (
    take && word_last |=> !word_valid && !word_last)
    else $error("words after end of page");
  busy_mirror_a: assert property (
    log_busy == word_valid) else $error("busy and valid differ");
endmodule

bind pec_event_log pec_event_log_checker u_chk (
  .sys_clk(sys_clk), .rst(rst), .log_req(log_req), .log_busy(log_busy),
  .word_valid(word_valid), .word_ready(word_ready),
  .word_data(word_data), .word_last(word_last));

// ===== testbench/pec_host_model.sv
// host side reader of the log page, prompt or stalling
`timescale 1ns/1ps
module pec_host_model (
  // clock
  input  wire logic        sys_clk,
  // read control
  input  wire logic        log_req,
  input  wire logic        log_busy,
  input  wire logic        slow,
  // word stream
  input  wire logic        word_valid,
  output logic             word_ready,
  input  wire logic [15:0] word_data,
  input  wire logic        word_last
);
  logic [15:0] pg [0:255];
  logic [8:0]  n;
  logic        done;
  logic [1:0]  ph;
  initial begin
    word_ready = 1'b0;
    n = 9'h000;
    done = 1'b0;
    ph = 2'h0;
  end
  // slow mode takes one word in four, so words must stand while stalled
  always @(posedge sys_clk) begin
    ph <= ph + 2'h1;
    word_ready <= #1 !slow || ph == 2'h3;
    if (log_req && !log_busy) begin
      n <= 9'h000;
      done <= 1'b0;
    end else if (word_valid && word_ready) begin
      pg[n[7:0]] <= word_data;
      n <= n + 9'h001;
      done <= word_last;
    end
  end
endmodule

// ===== testbench/test_pec_event_log.sv
// self-checking bench for the link event counter log
`timescale 1ns/1ps
module test_pec_event_log;
  logic        sys_clk, rst, cmd_done, cmd_status_err, cmd_err_icrc;
  logic        tx_rerr, tx_is_data, rx_rerr, rx_is_data, rx_crc_cause;
  logic        phy_ready, sig_fis_done, sig_fis_rok, bist_activate;
  logic        log_req, log_clear, word_valid, word_ready, word_last;
  logic        log_busy, slow;
  logic [15:0] word_data;
  logic [15:0] exp_v [0:10];
  int          bad_count;
  int          cmp_count;

  pec_event_log uut (.sys_clk(sys_clk), .rst(rst), .cmd_done(cmd_done),
    .cmd_status_err(cmd_status_err), .cmd_err_icrc(cmd_err_icrc),
    .tx_rerr(tx_rerr), .tx_is_data(tx_is_data), .rx_rerr(rx_rerr),
    .rx_is_data(rx_is_data), .rx_crc_cause(rx_crc_cause),
    .phy_ready(phy_ready), .sig_fis_done(sig_fis_done),
    .sig_fis_rok(sig_fis_rok), .bist_activate(bist_activate),
    .log_req(log_req), .log_clear(log_clear), .word_valid(word_valid),
    .word_ready(word_ready), .word_data(word_data),
    .word_last(word_last), .log_busy(log_busy));
  pec_host_model host (.sys_clk(sys_clk), .log_req(log_req),
    .log_busy(log_busy), .slow(slow), .word_valid(word_valid),
    .word_ready(word_ready), .word_data(word_data),
    .word_last(word_last));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // *****************
  // helpers
  // *****************
  task automatic tally_and_finish;
    $display("compares %0d errors %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    cmp_count++;
    if (got !== want) begin
      bad_count++;
      $display("Error at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic step;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic quiet;
    {cmd_done, cmd_status_err, cmd_err_icrc, tx_rerr, tx_is_data} = '0;
    {rx_rerr, rx_is_data, rx_crc_cause, phy_ready} = '0;
    {sig_fis_done, sig_fis_rok, bist_activate} = '0;
  endtask
  task automatic zero_exp;
    foreach (exp_v[i]) exp_v[i] = 16'h0000;
  endtask
  task automatic bump(input int i);
    if (exp_v[i] != 16'hffff) exp_v[i] = exp_v[i] + 16'h0001;
  endtask
  function automatic logic [15:0] ew(input int i);
    if (i < 2 || i > 23) return 16'h0000;
    if (i % 2 == 0) return {4'h1, pec_pkg::CODES[(i - 2) / 2]};
    return exp_v[(i - 3) / 2];
  endfunction
  // one event of kind k, held for a single cycle
  task automatic pulse(input int k);
    step;
    case (k)
      0: {cmd_done, cmd_status_err, cmd_err_icrc} = 3'h7;
      1: {cmd_done, cmd_status_err} = 2'h3;
      2: {tx_rerr, tx_is_data} = 2'h3;
      3: {rx_rerr, rx_is_data, rx_crc_cause} = 3'h7;
      4: tx_rerr = 1'b1;
      5: rx_rerr = 1'b1;
      6: phy_ready = 1'b1;
      7: {sig_fis_done, sig_fis_rok} = 2'h3;
      default: sig_fis_done = 1'b1;
    endcase
    case (k)
      0: bump(pec_pkg::I_ICRC);
      2: begin
        bump(pec_pkg::I_DATA_ALL);
        bump(pec_pkg::I_DATA_TX);
      end
      3: begin
        bump(pec_pkg::I_DATA_ALL);
        bump(pec_pkg::I_DATA_RX);
        bump(pec_pkg::I_RX_CRC);
      end
      4: begin
        bump(pec_pkg::I_ND_ALL);
        bump(pec_pkg::I_ND_TX);
      end
      5: begin
        bump(pec_pkg::I_ND_ALL);
        bump(pec_pkg::I_ND_RX);
        bump(pec_pkg::I_RX_OTHER);
      end
      6: bump(pec_pkg::I_PHY_RDY);
      7: bump(pec_pkg::I_SIG_FIS);
      default: ;
    endcase
    step;
    quiet;
  endtask
  // reads a whole page, with a stray request while busy
  task automatic read_page(input logic clr, input logic slw);
    int t;
    slow = slw;
    step;
    log_req = 1'b1;
    log_clear = clr;
    step;
    log_req = 1'b0;
    log_clear = 1'b0;
    repeat (3) step;
    log_req = 1'b1;
    step;
    log_req = 1'b0;
    t = 0;
    while (host.done !== 1'b1 && t < 3000) begin
      step;
      t++;
    end
    step;
    chk({15'h0000, host.done}, 16'h0001);
    chk({7'h00, host.n}, 16'h00ff);
    for (int i = 0; i < 255; i++) chk(host.pg[i], ew(i));
    if (clr) zero_exp;
  endtask
  // *****************
  // scenarios
  // *****************
  task automatic t_events;
    for (int k = 0; k < 9; k++) repeat (k + 1) pulse(k);
    // both directions refused in one cycle, data then non-data
    step;
    {tx_rerr, tx_is_data, rx_rerr, rx_is_data, rx_crc_cause} = 5'h1f;
    step;
    {tx_is_data, rx_is_data, rx_crc_cause} = 3'h0;
    step;
    quiet;
    bump(pec_pkg::I_DATA_ALL);
    bump(pec_pkg::I_DATA_ALL);
    bump(pec_pkg::I_DATA_TX);
    bump(pec_pkg::I_DATA_RX);
    bump(pec_pkg::I_RX_CRC);
    bump(pec_pkg::I_ND_ALL);
    bump(pec_pkg::I_ND_ALL);
    bump(pec_pkg::I_ND_TX);
    bump(pec_pkg::I_ND_RX);
    bump(pec_pkg::I_RX_OTHER);
    read_page(1'b0, 1'b1);
  endtask
  task automatic t_saturate;
    step;
    {cmd_done, cmd_status_err, cmd_err_icrc} = 3'h7;
    repeat (65540) @(posedge sys_clk);
    #1;
    quiet;
    exp_v[pec_pkg::I_ICRC] = 16'hffff;
    read_page(1'b0, 1'b0);
  endtask
  // an event in the clearing cycle survives as a count of one
  task automatic t_bist;
    step;
    {bist_activate, tx_rerr, tx_is_data} = 3'h7;
    step;
    quiet;
    zero_exp;
    exp_v[pec_pkg::I_DATA_ALL] = 16'h0001;
    exp_v[pec_pkg::I_DATA_TX] = 16'h0001;
    read_page(1'b0, 1'b0);
  endtask
  task automatic t_clear_read;
    repeat (2) pulse(5);
    read_page(1'b1, 1'b1);
    read_page(1'b0, 1'b0);
  endtask
  task automatic t_power;
    pulse(7);
    rst = 1'b1;
    repeat (2) step;
    rst = 1'b0;
    zero_exp;
    read_page(1'b0, 1'b0);
  endtask

  initial begin
    #1000000;
    bad_count++;
    tally_and_finish;
  end
  initial begin
    rst = 1'b1;
    log_req = 1'b0;
    log_clear = 1'b0;
    slow = 1'b0;
    quiet;
    zero_exp;
    repeat (2) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    read_page(1'b0, 1'b0);
    t_events;
    t_saturate;
    t_bist;
    t_clear_read;
    t_power;
    tally_and_finish;
  end
endmodule
